/* logic/dss_status_word.sv */
// status word encoder, LED driver and register slave for the drive power state machine
`timescale 1ns/1ps
module dss_status_word
	import dss_pkg::*;
#(
	parameter int BLINK_HALF_CYCLES = DSS_BLINK_HALF_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire dss_state_t drv_state,
	input wire logic latched_fault_flag,
	input wire logic live_warning_flag,
	input wire logic fault_class_err,
	input wire logic warn_class_err,
	input wire logic power_stage_supply,
	input wire logic [7:0] active_op_mode_view,
	input wire logic [7:0] mode_status_bits,
	output logic [15:0] drive_state_word,
	output logic drive_enable,
	output logic operation_enable,
	output logic status_led_a_green,
	output logic status_led_a_red,
	output logic status_led_b_green,
	output logic status_led_b_red,
	output logic irq
);
	dss_regs_t s_ff;
	dss_regs_t nxt_s;

	function automatic logic [7:0] low_byte(input dss_state_t st, input logic flt,
			input logic sup, input logic warn);
		logic [7:0] b;
		b = 8'h00;
		case (st)
			DSS_NOT_READY: b[3:0] = 4'h0;
			DSS_SWITCH_ON_DISABLED: begin
				b[DSS_SW_SOD] = 1'b1;
				b[3:0] = 4'h0;
			end
			DSS_READY_TO_SWITCH_ON: begin
				b[DSS_SW_QSTOP] = 1'b1;
				b[3:0] = 4'h1;
			end
			DSS_SWITCHED_ON: begin
				b[DSS_SW_QSTOP] = 1'b1;
				b[3:0] = 4'h3;
			end
			DSS_OPERATION_ENABLED: begin
				b[DSS_SW_QSTOP] = 1'b1;
				b[3:0] = 4'h7;
			end
			DSS_QUICK_STOP: b[3:0] = 4'h7;
			DSS_FAULT_REACTION: b[3:0] = 4'hf;
			DSS_FAULT: b[3:0] = 4'h8;
			default: b[3:0] = 4'h0;
		endcase
		// don't-care positions simply read as zero
		b[DSS_SW_FAULT] = b[DSS_SW_FAULT] | flt;
		b[DSS_SW_SUPPLY] = sup;
		b[DSS_SW_WARN] = warn;
		return b;
	endfunction : low_byte

	logic req;
	logic wr_hit;
	logic [7:0] cur_low;
	logic [DSS_IRQ_W-1:0] events;
	logic [DSS_IRQ_W-1:0] clr_mask;
	logic blink_tick;

	always_comb begin
		nxt_s = s_ff;
		req = avs_read | avs_write;
		// write lands at the edge where waitrequest is seen low
		wr_hit = avs_write & s_ff.ack & avs_byteenable[0];
		cur_low = low_byte(drv_state, latched_fault_flag, s_ff.sup_sync, live_warning_flag);

		// pin-level supply sense crosses in through two flops
		nxt_s.sup_meta = power_stage_supply;
		nxt_s.sup_sync = s_ff.sup_meta;

		// upper byte carried from the mode logic unchanged
		nxt_s.word = {mode_status_bits, cur_low};

		case (drv_state)
			DSS_SWITCHED_ON: nxt_s.drv_en = s_ff.ctrl_opt;
			DSS_OPERATION_ENABLED: nxt_s.drv_en = 1'b1;
			DSS_QUICK_STOP: nxt_s.drv_en = 1'b1;
			// hold whatever was in force when the fault hit
			DSS_FAULT_REACTION: nxt_s.drv_en = s_ff.drv_en;
			DSS_FAULT: nxt_s.drv_en = 1'b0;
			default: nxt_s.drv_en = 1'b0;
		endcase
		nxt_s.op_en = (drv_state == DSS_OPERATION_ENABLED);

		// symmetric blink from a prescaled enable pulse
		blink_tick = (s_ff.blink_cnt == DSS_BLINK_W'(BLINK_HALF_CYCLES - 1));
		if (blink_tick) begin
			nxt_s.blink_cnt = '0;
			nxt_s.blink = ~s_ff.blink;
		end else begin
			nxt_s.blink_cnt = s_ff.blink_cnt + DSS_BLINK_W'(1);
		end

		nxt_s.prev_state = drv_state;
		nxt_s.prev_fault = latched_fault_flag;
		nxt_s.prev_warn = live_warning_flag;
		events = '0;
		events[DSS_IRQ_STATE] = (drv_state != s_ff.prev_state);
		events[DSS_IRQ_FAULT] = latched_fault_flag & ~s_ff.prev_fault;
		events[DSS_IRQ_WARN] = live_warning_flag & ~s_ff.prev_warn;
		// word bit 4 is sup_sync one cycle late, so the first flop stays private
		events[DSS_IRQ_SUPPLY] = (s_ff.sup_sync != s_ff.word[DSS_SW_SUPPLY]);

		// one wait cycle per access; answer registered in the wait cycle
		nxt_s.ack = req & ~s_ff.ack;
		clr_mask = '0;
		if (wr_hit) begin
			case (avs_address)
				DSS_ADDR_CTRL: nxt_s.ctrl_opt = avs_writedata[0];
				DSS_ADDR_IRQ_CLEAR: clr_mask = avs_writedata[DSS_IRQ_W-1:0];
				DSS_ADDR_IRQ_ENABLE: nxt_s.irq_en = avs_writedata[DSS_IRQ_W-1:0];
				default: ;
			endcase
		end
		// a new event beats a simultaneous clear
		nxt_s.irq_st = (s_ff.irq_st & ~clr_mask) | events;

		if (avs_read & ~s_ff.ack) begin
			case (avs_address)
				// software decodes the state from this word alone
				DSS_ADDR_STATE_WORD: nxt_s.rdata = {16'h0000, s_ff.word};
				DSS_ADDR_CTRL: nxt_s.rdata = {31'h00000000, s_ff.ctrl_opt};
				DSS_ADDR_IRQ_STATUS: nxt_s.rdata = {28'h0000000, s_ff.irq_st};
				DSS_ADDR_IRQ_ENABLE: nxt_s.rdata = {28'h0000000, s_ff.irq_en};
				DSS_ADDR_MODE_VIEW: nxt_s.rdata = {24'h000000, active_op_mode_view};
				default: nxt_s.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_ff <= '{ack: 1'b0, rdata: 32'h00000000, word: DSS_WORD_RST, drv_en: 1'b0,
				op_en: 1'b0, sup_meta: 1'b0, sup_sync: 1'b0, ctrl_opt: DSS_CTRL_OPT_RST,
				irq_st: 4'h0, irq_en: DSS_IRQ_EN_RST, prev_state: DSS_NOT_READY,
				prev_fault: 1'b0, prev_warn: 1'b0, blink_cnt: 24'h000000, blink: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~s_ff.ack;
	assign avs_readdata = s_ff.rdata;
	assign drive_state_word = s_ff.word;
	assign drive_enable = s_ff.drv_en;
	assign operation_enable = s_ff.op_en;
	assign irq = |(s_ff.irq_st & s_ff.irq_en);

	// orange is red plus green; a fault overrides any warning
	always_comb begin
		if (fault_class_err) begin
			status_led_a_red = 1'b1;
			status_led_a_green = 1'b0;
			status_led_b_red = 1'b1;
			status_led_b_green = 1'b0;
		end else if (warn_class_err) begin
			status_led_a_red = 1'b1;
			status_led_a_green = 1'b1;
			status_led_b_red = 1'b1;
			status_led_b_green = 1'b1;
		end else begin
			status_led_a_red = 1'b0;
			status_led_a_green = 1'b1;
			status_led_b_red = 1'b0;
			status_led_b_green = s_ff.drv_en | s_ff.blink;
		end
	end
endmodule : dss_status_word

/* logic/dss_pkg.sv */
// constants and types for the drive state status word block
package dss_pkg;
	typedef enum logic [2:0] {
		DSS_NOT_READY,
		DSS_SWITCH_ON_DISABLED,
		DSS_READY_TO_SWITCH_ON,
		DSS_SWITCHED_ON,
		DSS_OPERATION_ENABLED,
		DSS_QUICK_STOP,
		DSS_FAULT_REACTION,
		DSS_FAULT
	} dss_state_t;

	localparam int DSS_CLK_HZ = 25_000_000;
	localparam int DSS_BLINK_HALF_MS = 500;
	localparam int DSS_BLINK_HALF_CYCLES = DSS_CLK_HZ / 1000 * DSS_BLINK_HALF_MS;
	localparam int DSS_BLINK_W = 24;

	// byte addresses of the software registers
	localparam logic [4:0] DSS_ADDR_STATE_WORD = 5'h00;
	localparam logic [4:0] DSS_ADDR_CTRL = 5'h04;
	localparam logic [4:0] DSS_ADDR_IRQ_STATUS = 5'h08;
	localparam logic [4:0] DSS_ADDR_IRQ_CLEAR = 5'h0c;
	localparam logic [4:0] DSS_ADDR_IRQ_ENABLE = 5'h10;
	localparam logic [4:0] DSS_ADDR_MODE_VIEW = 5'h14;

	// status word field positions
	localparam int DSS_SW_FAULT = 3;
	localparam int DSS_SW_SUPPLY = 4;
	localparam int DSS_SW_QSTOP = 5;
	localparam int DSS_SW_SOD = 6;
	localparam int DSS_SW_WARN = 7;

	// interrupt event bits
	localparam int DSS_IRQ_STATE = 0;
	localparam int DSS_IRQ_FAULT = 1;
	localparam int DSS_IRQ_WARN = 2;
	localparam int DSS_IRQ_SUPPLY = 3;
	localparam int DSS_IRQ_W = 4;

	localparam logic DSS_CTRL_OPT_RST = 1'b0;
	localparam logic [3:0] DSS_IRQ_EN_RST = 4'h0;
	localparam logic [15:0] DSS_WORD_RST = 16'h0000;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [15:0] word;
		logic drv_en;
		logic op_en;
		logic sup_meta;
		logic sup_sync;
		logic ctrl_opt;
		logic [DSS_IRQ_W-1:0] irq_st;
		logic [DSS_IRQ_W-1:0] irq_en;
		dss_state_t prev_state;
		logic prev_fault;
		logic prev_warn;
		logic [DSS_BLINK_W-1:0] blink_cnt;
		logic blink;
	} dss_regs_t;
endpackage : dss_pkg

/* sim/dss_chk.sv */
// port assertions for the status word block
`timescale 1ns/1ps
module dss_chk
	import dss_pkg::*;
#(
	parameter int BLINK_HALF_CYCLES = 4
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire dss_state_t drv_state,
	input wire logic latched_fault_flag,
	input wire logic live_warning_flag,
	input wire logic fault_class_err,
	input wire logic warn_class_err,
	input wire logic [15:0] drive_state_word,
	input wire logic drive_enable,
	input wire logic operation_enable,
	input wire logic status_led_a_green,
	input wire logic status_led_a_red,
	input wire logic status_led_b_green
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_idle;
		(!drive_enable && !fault_class_err && !warn_class_err) [*8];
	endsequence
	property p_rtso;
		drv_state == DSS_READY_TO_SWITCH_ON && !latched_fault_flag
			|=> drive_state_word[6:5] == 2'b01 && drive_state_word[3:0] == 4'h1;
	endproperty
	a_rtso: assert property (p_rtso) else $error("ready code wrong");
	property p_open;
		drv_state == DSS_OPERATION_ENABLED
			|=> drive_state_word[6:5] == 2'b01 && drive_state_word[2:0] == 3'h7 && operation_enable;
	endproperty
	a_open: assert property (p_open) else $error("op enabled code wrong");
	property p_qstop;
		drv_state == DSS_QUICK_STOP
			|=> drive_state_word[6:5] == 2'b00 && drive_state_word[2:0] == 3'h7 && drive_enable;
	endproperty
	a_qstop: assert property (p_qstop) else $error("quick stop code wrong");
	property p_fault;
		drv_state == DSS_FAULT |=> drive_state_word[6] == 1'b0 && drive_state_word[3:0] == 4'h8
			&& !drive_enable && !operation_enable;
	endproperty
	a_fault: assert property (p_fault) else $error("fault code wrong");
	property p_warn;
		1'b1 |=> drive_state_word[7] == $past(live_warning_flag);
	endproperty
	a_warn: assert property (p_warn) else $error("warning bit wrong");
	property p_leden;
		drive_enable && !fault_class_err && !warn_class_err |-> status_led_a_green && status_led_b_green;
	endproperty
	a_leden: assert property (p_leden) else $error("enabled leds wrong");
	property p_red;
		fault_class_err |-> status_led_a_red && !status_led_a_green;
	endproperty
	a_red: assert property (p_red) else $error("fault led not red");
	// half period of four in sim, so the led differs from four cycles back
	property p_blink;
		s_idle |-> status_led_b_green != $past(status_led_b_green, BLINK_HALF_CYCLES);
	endproperty
	a_blink: assert property (p_blink) else $error("led b not blinking");
endmodule : dss_chk

/* sim/dss_master.sv */
// bus master model reading and writing the block registers
`timescale 1ns/1ps
module dss_master (
	input wire logic core_clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable
);
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= wd;
		do @(posedge core_clk); while (avs_waitrequest);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// stale data must not look valid once released
		avs_writedata <= ~wd;
	endtask : xfer
endmodule : dss_master

/* sim/tb_top.sv */
// self-checking bench for the status word block
`timescale 1ns/1ps
module tb_top;
	import dss_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic lf = 1'b0, lw = 1'b0, fe = 1'b0, we = 1'b0, ps = 1'b0;
	logic [7:0] mv = 8'h00, mb = 8'h00;
	dss_state_t st = DSS_NOT_READY;
	logic [4:0] adr;
	logic rd_s, wr_s, wt, de, oe, ag, ar, bg, br, irq;
	logic [31:0] wd, rdat, d;
	logic [3:0] be;
	logic [15:0] sw;
	logic [7:0] exp_lo [8] = '{8'h10, 8'h50, 8'h31, 8'h33, 8'h37, 8'h17, 8'h1f, 8'h18};
	logic [1:0] exp_en [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h0};
	int miscompares = 0;
	int n_compared = 0;
	always #20 core_clk = ~core_clk;
	dss_master m (.core_clk(core_clk), .avs_waitrequest(wt), .avs_readdata(rdat),
		.avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
		.avs_byteenable(be));
	dss_status_word #(.BLINK_HALF_CYCLES(4)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt), .drv_state(st),
		.latched_fault_flag(lf), .live_warning_flag(lw), .fault_class_err(fe),
		.warn_class_err(we), .power_stage_supply(ps), .active_op_mode_view(mv),
		.mode_status_bits(mb), .drive_state_word(sw), .drive_enable(de),
		.operation_enable(oe), .status_led_a_green(ag), .status_led_a_red(ar),
		.status_led_b_green(bg), .status_led_b_red(br), .irq(irq));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task report_and_stop;
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		ps <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			st <= dss_state_t'(i);
			repeat (4) @(posedge core_clk);
			m.xfer(1'b0, DSS_ADDR_STATE_WORD, 32'h0, d);
			chk("state code", {24'h0, exp_lo[i]}, d & 32'h7f);
			chk("enables", {30'h0, exp_en[i]}, {30'h0, de, oe});
		end
		m.xfer(1'b1, DSS_ADDR_CTRL, 32'h1, d);
		st <= DSS_SWITCHED_ON;
		repeat (2) @(posedge core_clk);
		chk("option enable", 32'h1, {31'h0, de});
		lf <= 1'b1;
		lw <= 1'b1;
		we <= 1'b1;
		mb <= 8'ha5;
		mv <= 8'h3c;
		m.xfer(1'b1, DSS_ADDR_IRQ_ENABLE, 32'h2, d);
		chk("orange", 32'h3, {30'h0, ar, ag});
		chk("orange b", 32'h3, {30'h0, br, bg});
		m.xfer(1'b0, DSS_ADDR_CTRL, 32'h0, d);
		chk("ctrl readback", 32'h1, d);
		m.xfer(1'b0, DSS_ADDR_IRQ_ENABLE, 32'h0, d);
		chk("irq enable readback", 32'h2, d);
		m.xfer(1'b0, DSS_ADDR_STATE_WORD, 32'h0, d);
		chk("flag word", 32'ha5bb, d);
		m.xfer(1'b0, DSS_ADDR_MODE_VIEW, 32'h0, d);
		chk("mode view", 32'h3c, d);
		chk("irq set", 32'h1, {31'h0, irq});
		fe <= 1'b1;
		lf <= 1'b0;
		@(posedge core_clk);
		chk("red", 32'h2, {30'h0, ar, ag});
		chk("red b", 32'h2, {30'h0, br, bg});
		m.xfer(1'b1, DSS_ADDR_IRQ_CLEAR, 32'h2, d);
		@(posedge core_clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		m.xfer(1'b0, DSS_ADDR_IRQ_STATUS, 32'h0, d);
		chk("irq status", 32'hd, d);
		m.xfer(1'b0, 5'h18, 32'h0, d);
		chk("unmapped", 32'h0, d);
		report_and_stop();
	end
endmodule : tb_top
bind dss_status_word dss_chk #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .drv_state(drv_state),
	.latched_fault_flag(latched_fault_flag), .live_warning_flag(live_warning_flag),
	.fault_class_err(fault_class_err), .warn_class_err(warn_class_err),
	.drive_state_word(drive_state_word), .drive_enable(drive_enable),
	.operation_enable(operation_enable), .status_led_a_green(status_led_a_green),
	.status_led_a_red(status_led_a_red), .status_led_b_green(status_led_b_green));
